// file: src/speed_curve_defs.svh
`ifndef SPEED_CURVE_DEFS_SVH
`define SPEED_CURVE_DEFS_SVH

// ----------------------------------------
// configuration register offsets
// ----------------------------------------
`define OFS_HALT_KEEP 8'h02
`define OFS_RUN 8'h03
`define OFS_KNEE 8'h04
`define OFS_TOP 8'h05
`define OFS_BASE_HI 8'h06
`define OFS_BASE_LO_HYS 8'h07
`define OFS_GAIN1_HI 8'h08
`define OFS_GAIN1_LO_OPT 8'h09
`define OFS_GAIN2_HI 8'h0A
`define OFS_GAIN2_LO 8'h0B

// ----------------------------------------
// field positions
// ----------------------------------------
`define KEEP_RUNNING_BIT 7
`define ZERO_FULL_BIT 0
`define TOP_BYPASS_BIT 1
`define DIRECT_DRIVE_BIT 0

// ----------------------------------------
// decode constants and reset values
// ----------------------------------------
`define TOP_OFFSET 10'h101
`define GAIN_SHIFT 6
`define FULL_DUTY 9'h1FF
`define RST_TARGET 16'h0000
`define RST_DUTY 9'h000

`endif

// file: src/speed_curve_pkg.sv
package speed_curve_pkg;

  typedef enum logic {
    MODE_CLOSED,
    MODE_BYPASS
  } loop_mode_t;

  typedef enum logic {
    DIR_RISING,
    DIR_FALLING
  } cmd_dir_t;

endpackage

// file: src/closed_loop_speed_curve.sv
// Summary of operation
// - run = code/512, halt = code*2/512, top = (code+257)/512.
// - base speed is 12 bits, 1 rpm per count, from two registers.
// - above run, speed rises from base at gain1/64 rpm per code.
// - no maximum setting; maximum follows run, top and gain1.
// - return hysteresis is (code+1) times 0.4 percent.
// - keep off, halt<cmd<=run: zero when rising, base when falling.
// - keep on, zero-full off: cmd at or below run gives base.
// - zero-full on: 0% gives max or 100%; below halt only with keep.
// - keep off, zero-full off: cmd at or below halt gives zero.
// - knee point = code*2/512.
// - with knee, gain1 applies from run to knee, starting at base.
// - above knee, gain2 continues from knee speed up to top.
// - knee works together with bypass and low-command options.
// - bypass on: cmd at or above top drives output duty = input duty.
// - leave bypass when cmd falls to top minus 2*(hys+1) codes.
// - curve used only while direct-drive select is zero.
// - command resolved to 9 bits, unit 1/512 full scale.
`include "speed_curve_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module closed_loop_speed_curve #(
  parameter int TARGET_W = 16
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [8:0] speed_command,
  input wire logic [7:0] halt_threshold_and_keep_running,
  input wire logic [7:0] run_threshold,
  input wire logic [7:0] knee_point,
  input wire logic [7:0] top_threshold,
  input wire logic [7:0] base_speed_high,
  input wire logic [7:0] base_speed_low_and_hysteresis,
  input wire logic [7:0] first_gain_high,
  input wire logic [7:0] first_gain_low_and_options,
  input wire logic [7:0] second_gain_high,
  input wire logic [7:0] second_gain_low,
  output logic [TARGET_W-1:0] target_speed_rpm,
  output logic direct_duty_active,
  output logic [8:0] direct_duty,
  output logic closed_loop_active
);

  // ----------------------------------------
  // arithmetic helpers
  // ----------------------------------------
  // saturate a wide result into the target width instead of wrapping
  function automatic logic [TARGET_W-1:0] sat_target(input logic [23:0] v);
    logic [23:0] lim;
    lim = 24'(({TARGET_W{1'b1}}));
    if (v > lim) begin
      sat_target = {TARGET_W{1'b1}};
    end else begin
      sat_target = v[TARGET_W-1:0];
    end
  endfunction

  // start speed plus gain*span/64, fraction dropped
  function automatic logic [23:0] seg_speed(input logic [23:0] start, input logic [13:0] gain,
                                            input logic [9:0] span);
    logic [23:0] prod;
    prod = 24'(gain) * 24'(span);
    seg_speed = start + (prod >> `GAIN_SHIFT);
  endfunction

  // non-negative difference of two command levels
  function automatic logic [9:0] span_of(input logic [9:0] hi, input logic [9:0] lo);
    if (hi > lo) begin
      span_of = hi - lo;
    end else begin
      span_of = 10'h000;
    end
  endfunction

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  logic keep_running_enable;
  logic zero_command_full_speed;
  logic top_bypass_enable;
  logic direct_drive_select;
  logic [6:0] halt_threshold_code;
  logic [7:0] run_threshold_code;
  logic [7:0] knee_point_code;
  logic [7:0] top_threshold_code;
  logic [3:0] top_return_hysteresis;
  logic [11:0] base_speed_rpm;
  logic [13:0] gain_first_segment;
  logic [13:0] gain_second_segment;

  assign keep_running_enable = halt_threshold_and_keep_running[`KEEP_RUNNING_BIT];
  assign halt_threshold_code = halt_threshold_and_keep_running[6:0];
  assign run_threshold_code = run_threshold;
  assign knee_point_code = knee_point;
  assign top_threshold_code = top_threshold;
  assign base_speed_rpm = {base_speed_high, base_speed_low_and_hysteresis[7:4]};
  assign top_return_hysteresis = base_speed_low_and_hysteresis[3:0];
  assign gain_first_segment = {first_gain_high, first_gain_low_and_options[7:2]};
  assign gain_second_segment = {second_gain_high, second_gain_low[7:2]};
  assign top_bypass_enable = first_gain_low_and_options[`TOP_BYPASS_BIT];
  assign zero_command_full_speed = first_gain_low_and_options[`ZERO_FULL_BIT];
  assign direct_drive_select = second_gain_low[`DIRECT_DRIVE_BIT];

  // ----------------------------------------
  // thresholds in 1/512 command units
  // ----------------------------------------
  // everything compared at 10 bits: the top level reaches 512
  logic [9:0] cmd;
  logic [9:0] halt_lvl;
  logic [9:0] run_lvl;
  logic [9:0] top_lvl;
  logic [9:0] knee_lvl;
  logic [9:0] return_lvl;
  logic knee_used;

  assign cmd = {1'b0, speed_command};
  assign halt_lvl = {2'b00, halt_threshold_code, 1'b0};
  assign run_lvl = {2'b00, run_threshold_code};
  assign top_lvl = {2'b00, top_threshold_code} + `TOP_OFFSET;
  assign knee_lvl = {1'b0, knee_point_code, 1'b0};
  assign knee_used = (knee_point_code != 8'h00);
  // (hys+1)*2 codes = (hys+1)*0.4 percent
  assign return_lvl = top_lvl - {4'h0, ({1'b0, top_return_hysteresis} + 5'h01), 1'b0};

  // ----------------------------------------
  // speed curve
  // ----------------------------------------
  logic [9:0] eff_cmd;
  logic [9:0] seg1_end;
  logic [23:0] knee_speed;
  logic [23:0] curve_speed;
  logic [23:0] max_speed;

  // one curve evaluator serves both the live command and the top-threshold maximum
  function automatic logic [23:0] curve_at(input logic [9:0] c, input logic [9:0] s1_end,
                                           input logic [23:0] k_speed);
    if (knee_used && (c > knee_lvl)) begin
      curve_at = seg_speed(k_speed, gain_second_segment, span_of(c, knee_lvl));
    end else begin
      curve_at = seg_speed(24'(base_speed_rpm), gain_first_segment, span_of(c, run_lvl));
    end
  endfunction

  always_comb begin
    // without bypass, commands past top see the top-threshold speed
    if (cmd > top_lvl) begin
      eff_cmd = top_lvl;
    end else begin
      eff_cmd = cmd;
    end
    seg1_end = knee_lvl;
    knee_speed = seg_speed(24'(base_speed_rpm), gain_first_segment, span_of(seg1_end, run_lvl));
    curve_speed = curve_at(eff_cmd, seg1_end, knee_speed);
    max_speed = curve_at(top_lvl, seg1_end, knee_speed);
  end

  // ----------------------------------------
  // command direction memory
  // ----------------------------------------
  logic [8:0] last_cmd_ff;
  logic [8:0] nxt_last_cmd;
  speed_curve_pkg::cmd_dir_t dir_ff;
  speed_curve_pkg::cmd_dir_t nxt_dir;

  always_comb begin
    nxt_last_cmd = speed_command;
    nxt_dir = dir_ff;
    // a steady command keeps the previous direction
    if (speed_command > last_cmd_ff) begin
      nxt_dir = speed_curve_pkg::DIR_RISING;
    end else if (speed_command < last_cmd_ff) begin
      nxt_dir = speed_curve_pkg::DIR_FALLING;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      last_cmd_ff <= 9'h000;
      dir_ff <= speed_curve_pkg::DIR_RISING;
    end else begin
      last_cmd_ff <= nxt_last_cmd;
      dir_ff <= nxt_dir;
    end
  end

  // ----------------------------------------
  // top bypass state
  // ----------------------------------------
  speed_curve_pkg::loop_mode_t mode_ff;
  speed_curve_pkg::loop_mode_t nxt_mode;

  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      speed_curve_pkg::MODE_CLOSED: begin
        if (top_bypass_enable && !direct_drive_select && (cmd >= top_lvl)) begin
          nxt_mode = speed_curve_pkg::MODE_BYPASS;
        end
      end
      speed_curve_pkg::MODE_BYPASS: begin
        // hysteresis stops chatter between loop and bypass near the top
        if (!top_bypass_enable || direct_drive_select || (cmd <= return_lvl)) begin
          nxt_mode = speed_curve_pkg::MODE_CLOSED;
        end
      end
      default: begin
        nxt_mode = speed_curve_pkg::MODE_CLOSED;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_ff <= speed_curve_pkg::MODE_CLOSED;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // ----------------------------------------
  // output selection
  // ----------------------------------------
  logic [TARGET_W-1:0] target_ff;
  logic [TARGET_W-1:0] nxt_target;
  logic direct_ff;
  logic nxt_direct;
  logic [8:0] duty_ff;
  logic [8:0] nxt_duty;
  logic full_request;

  always_comb begin
    nxt_target = `RST_TARGET;
    nxt_direct = 1'b0;
    nxt_duty = `RST_DUTY;
    full_request = 1'b0;
    if (direct_drive_select) begin
      nxt_target = `RST_TARGET;
    end else if (cmd == 10'h000) begin
      if (zero_command_full_speed) begin
        full_request = 1'b1;
      end else if (keep_running_enable) begin
        nxt_target = sat_target(24'(base_speed_rpm));
      end else begin
        nxt_target = `RST_TARGET;
      end
    end else if (cmd <= halt_lvl) begin
      if (keep_running_enable && zero_command_full_speed) begin
        full_request = 1'b1;
      end else if (keep_running_enable) begin
        nxt_target = sat_target(24'(base_speed_rpm));
      end else begin
        nxt_target = `RST_TARGET;
      end
    end else if (cmd <= run_lvl) begin
      // the fresh direction is used so a rising step never shows base for a cycle
      if (keep_running_enable || (nxt_dir == speed_curve_pkg::DIR_FALLING)) begin
        nxt_target = sat_target(24'(base_speed_rpm));
      end else begin
        nxt_target = `RST_TARGET;
      end
    end else if (nxt_mode == speed_curve_pkg::MODE_BYPASS) begin
      nxt_direct = 1'b1;
      nxt_duty = speed_command;
    end else begin
      nxt_target = sat_target(curve_speed);
    end
    // full speed means 100 percent duty with bypass, maximum rpm without
    if (full_request) begin
      if (top_bypass_enable) begin
        nxt_direct = 1'b1;
        nxt_duty = `FULL_DUTY;
      end else begin
        nxt_target = sat_target(max_speed);
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      target_ff <= `RST_TARGET;
      direct_ff <= 1'b0;
      duty_ff <= `RST_DUTY;
    end else begin
      target_ff <= nxt_target;
      direct_ff <= nxt_direct;
      duty_ff <= nxt_duty;
    end
  end

  assign target_speed_rpm = target_ff;
  assign direct_duty_active = direct_ff;
  assign direct_duty = duty_ff;
  assign closed_loop_active = !direct_drive_select;

endmodule

`default_nettype wire

// file: tb/speed_curve_checker.sv
`timescale 1ns/10ps
`default_nettype none
module speed_curve_checker #(
  parameter int TARGET_W = 16
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [8:0] speed_command,
  input wire logic [7:0] halt_threshold_and_keep_running,
  input wire logic [7:0] run_threshold,
  input wire logic [7:0] knee_point,
  input wire logic [7:0] top_threshold,
  input wire logic [7:0] base_speed_high,
  input wire logic [7:0] base_speed_low_and_hysteresis,
  input wire logic [7:0] first_gain_high,
  input wire logic [7:0] first_gain_low_and_options,
  input wire logic [7:0] second_gain_high,
  input wire logic [7:0] second_gain_low,
  input wire logic [TARGET_W-1:0] target_speed_rpm,
  input wire logic direct_duty_active,
  input wire logic [8:0] direct_duty,
  input wire logic closed_loop_active
);
  // ----------------------------------------
  // decoded levels in command codes
  // ----------------------------------------
  logic [9:0] cmd, top_lvl, ret_lvl, halt_lvl, run_lvl;
  logic [11:0] base;
  logic keep, zf, byp, sel, duty_cmd;
  assign cmd = {1'b0, speed_command};
  assign top_lvl = {2'b00, top_threshold} + 10'h101;
  assign ret_lvl = top_lvl - {5'h00, base_speed_low_and_hysteresis[3:0], 1'b0} - 10'h002;
  assign halt_lvl = {2'b00, halt_threshold_and_keep_running[6:0], 1'b0};
  assign run_lvl = {2'b00, run_threshold};
  assign base = {base_speed_high, base_speed_low_and_hysteresis[7:4]};
  assign keep = halt_threshold_and_keep_running[7];
  assign zf = first_gain_low_and_options[0];
  assign sel = second_gain_low[0];
  assign byp = first_gain_low_and_options[1] && !sel;
  // full output is 0x1FF too, so only other duties prove a copied command
  assign duty_cmd = direct_duty_active && direct_duty != 9'h1FF;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_flag; closed_loop_active == !sel; endproperty
  a_flag: assert property (p_flag) else $error("loop flag wrong");
  property p_open; sel |=> target_speed_rpm == '0 && !direct_duty_active; endproperty
  a_open: assert property (p_open) else $error("curve active in open loop");
  property p_idle; !direct_duty_active |-> direct_duty == 9'h000; endproperty
  a_idle: assert property (p_idle) else $error("duty without direct mode");
  property p_quiet; direct_duty_active |-> target_speed_rpm == '0; endproperty
  a_quiet: assert property (p_quiet) else $error("target during direct mode");
  property p_copy; duty_cmd |-> direct_duty == $past(speed_command); endproperty
  a_copy: assert property (p_copy) else $error("duty not the command");
  property p_enter; byp && cmd >= top_lvl |=> direct_duty_active && direct_duty == $past(speed_command); endproperty
  a_enter: assert property (p_enter) else $error("no bypass at top");
  property p_stay; duty_cmd && byp && cmd > ret_lvl |=> direct_duty_active; endproperty
  a_stay: assert property (p_stay) else $error("bypass left early");
  property p_leave; direct_duty_active && byp && cmd <= ret_lvl && cmd > run_lvl |=> !direct_duty_active; endproperty
  a_leave: assert property (p_leave) else $error("bypass not left");
  property p_halt; !keep && !zf && !sel && cmd <= halt_lvl |=> target_speed_rpm == '0 && !direct_duty_active; endproperty
  a_halt: assert property (p_halt) else $error("no stop at low command");
  property p_keep; keep && !zf && !sel && cmd <= run_lvl |=> target_speed_rpm == TARGET_W'($past(base)); endproperty
  a_keep: assert property (p_keep) else $error("base not kept");
  property p_rise; !keep && !sel && cmd > halt_lvl && cmd <= run_lvl && speed_command > $past(speed_command)
    |=> target_speed_rpm == '0; endproperty
  a_rise: assert property (p_rise) else $error("rising command started");
  c_copy: cover property (duty_cmd);
  c_full: cover property (direct_duty == 9'h1FF);
  c_exit: cover property ($fell(direct_duty_active));
endmodule
bind closed_loop_speed_curve speed_curve_checker #(.TARGET_W(TARGET_W)) u_chk (.*);
`default_nettype wire

// file: tb/speed_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "speed_curve_defs.svh"
module speed_host (
  input wire logic mclk,
  output logic [8:0] speed_command,
  output logic [7:0] halt_threshold_and_keep_running,
  output logic [7:0] run_threshold,
  output logic [7:0] knee_point,
  output logic [7:0] top_threshold,
  output logic [7:0] base_speed_high,
  output logic [7:0] base_speed_low_and_hysteresis,
  output logic [7:0] first_gain_high,
  output logic [7:0] first_gain_low_and_options,
  output logic [7:0] second_gain_high,
  output logic [7:0] second_gain_low
);
  // ----------------------------------------
  // host register image
  // ----------------------------------------
  // no reset value is known; zero keeps the curve at rest until written
  logic [7:0] regs_ff [2:11] = '{default: 8'h00};
  initial speed_command = 9'h000;
  assign halt_threshold_and_keep_running = regs_ff[2];
  assign run_threshold = regs_ff[3];
  assign knee_point = regs_ff[4];
  assign top_threshold = regs_ff[5];
  assign base_speed_high = regs_ff[6];
  assign base_speed_low_and_hysteresis = regs_ff[7];
  assign first_gain_high = regs_ff[8];
  assign first_gain_low_and_options = regs_ff[9];
  assign second_gain_high = regs_ff[10];
  assign second_gain_low = regs_ff[11];
  // writes outside the map are dropped
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    if (a >= `OFS_HALT_KEEP && a <= `OFS_GAIN2_LO) begin
      regs_ff[a[3:0]] <= d;
    end
  endtask
  task automatic put(input logic [8:0] c);
    @(posedge mclk);
    speed_command <= c;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_closed_loop_speed_curve.sv
`timescale 1ns/10ps
`default_nettype none
`include "speed_curve_defs.svh"
module tb_closed_loop_speed_curve;
  localparam int RUN = 102;
  localparam int TOPL = 461;
  localparam int BASE = 1500;
  localparam logic [13:0] G1 = 14'h0967;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [8:0] speed_command, direct_duty;
  logic [7:0] halt_threshold_and_keep_running, run_threshold, knee_point, top_threshold, base_speed_high;
  logic [7:0] base_speed_low_and_hysteresis, first_gain_high, first_gain_low_and_options;
  logic [7:0] second_gain_high, second_gain_low;
  logic [15:0] target_speed_rpm;
  logic direct_duty_active, closed_loop_active;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #4 mclk = ~mclk;
  speed_host u_host (.*);
  closed_loop_speed_curve u_dut (.*);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] seg(input int b, input int g, input int span);
    int v;
    v = b + g * span / 64;
    return (v > 65535) ? 16'hFFFF : v[15:0];
  endfunction
  // halt 46, run 102, top 204, base 1500, hysteresis 9
  task automatic cfg(input logic keep, input logic zf, input logic byp, input logic sel, input logic [7:0] knee,
      input logic [13:0] g1, input logic [13:0] g2);
    u_host.wr(`OFS_HALT_KEEP, {keep, 7'h2E});
    u_host.wr(`OFS_RUN, 8'h66);
    u_host.wr(`OFS_KNEE, knee);
    u_host.wr(`OFS_TOP, 8'hCC);
    u_host.wr(`OFS_BASE_HI, 8'h5D);
    u_host.wr(`OFS_BASE_LO_HYS, 8'hC9);
    u_host.wr(`OFS_GAIN1_HI, g1[13:6]);
    u_host.wr(`OFS_GAIN1_LO_OPT, {g1[5:0], byp, zf});
    u_host.wr(`OFS_GAIN2_HI, g2[13:6]);
    u_host.wr(`OFS_GAIN2_LO, {g2[5:0], 1'b0, sel});
  endtask
  task automatic go(input logic [8:0] c, input logic [15:0] t, input logic a, input logic [8:0] d);
    u_host.put(c);
    repeat (2) @(posedge mclk);
    #1;
    chk(target_speed_rpm, t);
    chk({15'h0000, direct_duty_active}, {15'h0000, a});
    chk({7'h00, direct_duty}, {7'h00, d});
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 1000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    cfg(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, G1, 14'h0000);
    go(9'h0C8, seg(BASE, G1, 200 - RUN), 1'b0, 9'h000);
    chk({15'h0000, closed_loop_active}, 16'h0001);
    go(9'h1FF, seg(BASE, G1, TOPL - RUN), 1'b0, 9'h000);
    go(9'h01E, 16'h0000, 1'b0, 9'h000);
    go(9'h000, 16'h0000, 1'b0, 9'h000);
    go(9'h064, 16'h0000, 1'b0, 9'h000);
    go(9'h1D6, seg(BASE, G1, TOPL - RUN), 1'b0, 9'h000);
    go(9'h064, seg(BASE, 0, 0), 1'b0, 9'h000);
    go(9'h064, seg(BASE, 0, 0), 1'b0, 9'h000);
    cfg(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, G1, 14'h0000);
    go(9'h000, seg(BASE, 0, 0), 1'b0, 9'h000);
    go(9'h01E, seg(BASE, 0, 0), 1'b0, 9'h000);
    cfg(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, G1, 14'h0000);
    go(9'h000, seg(BASE, G1, TOPL - RUN), 1'b0, 9'h000);
    go(9'h01E, 16'h0000, 1'b0, 9'h000);
    cfg(1'b1, 1'b1, 1'b0, 1'b0, 8'h00, G1, 14'h0000);
    go(9'h01E, seg(BASE, G1, TOPL - RUN), 1'b0, 9'h000);
    cfg(1'b1, 1'b1, 1'b1, 1'b0, 8'h00, G1, 14'h0000);
    go(9'h000, 16'h0000, 1'b1, 9'h1FF);
    cfg(1'b0, 1'b0, 1'b1, 1'b0, 8'h00, G1, 14'h0000);
    go(9'h1D6, 16'h0000, 1'b1, 9'h1D6);
    go(9'h1BA, 16'h0000, 1'b1, 9'h1BA);
    go(9'h1B9, seg(BASE, G1, 441 - RUN), 1'b0, 9'h000);
    cfg(1'b0, 1'b0, 1'b1, 1'b0, 8'h80, 14'h05AF, 14'h0C32);
    go(9'h100, seg(BASE, 1455, 256 - RUN), 1'b0, 9'h000);
    go(9'h101, seg(seg(BASE, 1455, 256 - RUN), 3122, 1), 1'b0, 9'h000);
    go(9'h12C, seg(seg(BASE, 1455, 256 - RUN), 3122, 300 - 256), 1'b0, 9'h000);
    go(9'h1D6, 16'h0000, 1'b1, 9'h1D6);
    cfg(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, G1, 14'h0000);
    go(9'h0C8, 16'h0000, 1'b0, 9'h000);
    chk({15'h0000, closed_loop_active}, 16'h0000);
    cfg(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 14'h3FFF, 14'h0000);
    u_host.wr(`OFS_RUN, 8'h00);
    u_host.wr(`OFS_TOP, 8'hFF);
    u_host.wr(`OFS_BASE_HI, 8'hFF);
    u_host.wr(`OFS_BASE_LO_HYS, 8'hF9);
    go(9'h1FF, seg(4095, 16383, 511), 1'b0, 9'h000);
    tally_and_finish;
  end
endmodule
`default_nettype wire
